/* adcc_pkg.sv */
// Package with register map, field positions, reset values and timing for the converter block
package adcc_pkg;
    // Register byte offsets on the APB bus
    localparam logic [7:0] CONTROL_OFFSET = 8'h00;
    localparam logic [7:0] RESULT_OFFSET = 8'h04;
    localparam logic [7:0] SLEEP_OFFSET = 8'h08;
    // Control register field positions
    localparam int ENABLE_BIT = 0;
    localparam int BUSY_BIT = 1;
    localparam int CHAN_LO_BIT = 2;
    localparam int CHAN_HI_BIT = 3;
    localparam int PIN0_SEL_BIT = 6;
    localparam int PIN1_SEL_BIT = 7;
    // Values after reset; the channel default is also loaded on sleep entry
    localparam logic [1:0] CHAN_DEFAULT = 2'h3;
    localparam logic [1:0] PINSEL_DEFAULT = 2'h3;
    // Mask of implemented control bits
    localparam logic [7:0] CONTROL_MASK = 8'hcf;
    // Conversion timing in instruction cycles and clocks per instruction cycle
    localparam int CONV_INSTR_CYCLES = 13;
    localparam int CLOCKS_PER_INSTR = 4;
    localparam int CONV_CLOCKS = CONV_INSTR_CYCLES * CLOCKS_PER_INSTR;
    localparam int SHIFT_COUNT = 9;
    // Clocks of sampling before the first shift, the rest paced evenly
    localparam int STEP_CLOCKS = CONV_CLOCKS / (SHIFT_COUNT + 1);
    localparam int SAMPLE_CLOCKS = CONV_CLOCKS - STEP_CLOCKS * SHIFT_COUNT;
    localparam logic [7:0] SAMPLE_COUNT = 8'(SAMPLE_CLOCKS - 1);
    localparam logic [7:0] STEP_COUNT = 8'(STEP_CLOCKS - 1);
    // Conversion state machine
    typedef enum logic [1:0] {
        ADCC_IDLE = 2'b00,
        ADCC_SAMPLE = 2'b01,
        ADCC_SHIFT = 2'b11
    } adcc_state_t;
endpackage

/* adcc_sar.sv */
// Successive-approximation sequencer with leading-one result register
`timescale 1ns/1ps
module adcc_sar import adcc_pkg::*; #(
    parameter int WIDTH = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic start,
    input wire logic abort,
    input wire logic comp_in,
    output logic busy,
    output logic done_pulse,
    output logic [WIDTH-1:0] result
);
    adcc_state_t state;
    logic [7:0] timer;
    logic [WIDTH:0] shreg;
    logic timer_zero;
    logic last_shift;
    wire [WIDTH:0] below_clear;
    wire [WIDTH:0] mark;
    wire [WIDTH:0] next_shreg;

    assign timer_zero = (timer == 8'h00);
    assign last_shift = shreg[0];
    assign busy = (state != ADCC_IDLE);

    // Marker is the lowest set bit: it takes the compare bit and moves down one place
    assign below_clear[0] = 1'b1;
    genvar g;
    for (g = 0; g <= WIDTH; g = g + 1) begin : g_bit
        assign mark[g] = shreg[g] && below_clear[g];
        if (g < WIDTH) begin : g_inner
            assign below_clear[g+1] = below_clear[g] && !shreg[g];
            assign next_shreg[g] = mark[g] ? comp_in : (mark[g+1] || shreg[g]);
        end else begin : g_top
            assign next_shreg[g] = mark[g] ? comp_in : shreg[g];
        end
    end

    // Sequencer: sample, clear, then shift the marker through nine times
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ADCC_IDLE;
            timer <= 8'h00;
            shreg <= '0;
            done_pulse <= 1'b0;
        end else if (clk_en) begin
            done_pulse <= 1'b0;
            if (abort) begin
                state <= ADCC_IDLE; // Partial result stays
            end else begin
                case (state)
                    ADCC_IDLE: begin
                        if (start) begin
                            state <= ADCC_SAMPLE;
                            timer <= SAMPLE_COUNT;
                        end
                    end
                    ADCC_SAMPLE: begin
                        if (timer_zero) begin
                            // Clear, marker parked just above the result's MSB
                            shreg <= {1'b1, {WIDTH{1'b0}}};
                            state <= ADCC_SHIFT;
                            timer <= STEP_COUNT;
                        end else begin
                            timer <= timer - 8'h01;
                        end
                    end
                    ADCC_SHIFT: begin
                        if (timer_zero) begin
                            // Stuff compare bit at the marker, marker moves right
                            shreg <= next_shreg;
                            timer <= STEP_COUNT;
                            if (last_shift) begin
                                state <= ADCC_IDLE; // Ninth shift ends it
                                done_pulse <= 1'b1;
                            end
                        end else begin
                            timer <= timer - 8'h01;
                        end
                    end
                    default: state <= ADCC_IDLE;
                endcase
            end
        end
    end

    assign result = shreg[WIDTH-1:0];
endmodule

/* adcc_top.sv */
// Converter control and result registers behind an APB slave
`timescale 1ns/1ps
module adcc_top import adcc_pkg::*; #(
    parameter int WIDTH = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sleep_enter,
    input wire logic comp_in,
    output logic converter_power,
    output logic pin0_analog_select,
    output logic pin1_analog_select,
    output logic [1:0] channel_select,
    output logic reference_select,
    output logic sample_active,
    output logic conversion_done
);
    logic converter_enable;
    logic [1:0] chan;
    logic [1:0] pinsel;
    logic busy;
    logic done_pulse;
    logic [WIDTH-1:0] result;
    logic [31:0] next_prdata;

    // Bus decode
    wire access = psel && penable;
    wire wr = access && pwrite;
    wire hit_ctrl = (paddr == CONTROL_OFFSET);
    wire hit_res = (paddr == RESULT_OFFSET);
    wire hit_sleep = (paddr == SLEEP_OFFSET);
    wire mapped = hit_ctrl || hit_res || hit_sleep;
    wire wr_ctrl = wr && hit_ctrl && pstrb[0] && clk_en;
    wire wr_sleep = wr && hit_sleep && pstrb[0] && pwdata[0] && clk_en;
    wire sleep_now = sleep_enter || wr_sleep;
    // Start only when enabled and idle
    wire start = wr_ctrl && pwdata[BUSY_BIT] && !busy
                 && pwdata[ENABLE_BIT] && !sleep_now;
    // Abort by software clearing busy, disabling, or sleep
    wire abort = busy && (sleep_now
                 || (wr_ctrl && (!pwdata[BUSY_BIT] || !pwdata[ENABLE_BIT])));

    // Read view of the control register, unimplemented bits zero
    wire [7:0] ctrl_view = {pinsel[1], pinsel[0], 2'b00, chan, busy, converter_enable}
                           & CONTROL_MASK;

    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    // Control fields: enable, channel, pin selects
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            converter_enable <= 1'b0;
            chan <= CHAN_DEFAULT;
            pinsel <= PINSEL_DEFAULT;
        end else if (clk_en) begin
            if (sleep_now) begin
                converter_enable <= 1'b0;
                chan <= CHAN_DEFAULT;
            end else if (wr_ctrl) begin
                converter_enable <= pwdata[ENABLE_BIT];
                chan <= pwdata[CHAN_HI_BIT:CHAN_LO_BIT];
                pinsel <= {pwdata[PIN1_SEL_BIT], pwdata[PIN0_SEL_BIT]};
            end
        end
    end

    // Read data mux, registered
    always_comb begin
        next_prdata = 32'h0000_0000;
        if (hit_ctrl) next_prdata = {24'h00_0000, ctrl_view};
        else if (hit_res) next_prdata = {{(32 - WIDTH){1'b0}}, result};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) prdata <= 32'h0000_0000;
        else if (clk_en && psel && !penable && !pwrite) prdata <= next_prdata;
    end

    // Sequencer; hardware clears busy at the ninth shift
    adcc_sar #(.WIDTH(WIDTH)) u_sar (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .start(start),
        .abort(abort),
        .comp_in(comp_in),
        .busy(busy),
        .done_pulse(done_pulse),
        .result(result)
    );

    // Pin and analog front-end controls; pins, channel and reference independent of enable
    assign pin0_analog_select = pinsel[0];
    assign pin1_analog_select = pinsel[1];
    assign channel_select = chan;
    assign reference_select = chan[1];
    assign converter_power = converter_enable;
    assign sample_active = busy;
    assign conversion_done = done_pulse;
endmodule

/* adcc_top_assertions.sv */
// Port-level assertions for the converter control block
`timescale 1ns/1ps
module adcc_top_assertions import adcc_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic sleep_enter,
    input wire logic converter_power,
    input wire logic pin0_analog_select,
    input wire logic pin1_analog_select,
    input wire logic [1:0] channel_select,
    input wire logic reference_select,
    input wire logic sample_active,
    input wire logic conversion_done
);
    logic [7:0] cnt;
    // Decoded control write and pin pair
    wire ctrl_wr = psel && penable && pwrite && clk_en && pstrb[0] && paddr == CONTROL_OFFSET;
    wire [1:0] pins = {pin1_analog_select, pin0_analog_select};
    // Clocks spent busy in the current conversion
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cnt <= 8'h00;
        else if (clk_en)
            cnt <= sample_active ? cnt + 8'h01 : 8'h00;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_sleep;
        sleep_enter && clk_en && !ctrl_wr;
    endsequence
    sequence s_abort;
        sample_active && ctrl_wr && !pwdata[BUSY_BIT];
    endsequence
    AST_REF: assert property (reference_select == channel_select[1])
        else $error("reference select wrong");
    AST_WRITE: assert property (ctrl_wr && !sleep_enter |=>
        {pins, channel_select, converter_power} ==
        {$past(pwdata[7:6]), $past(pwdata[3:2]), $past(pwdata[0])}) else $error("field write");
    AST_START: assert property ($rose(sample_active) |->
        $past(ctrl_wr && pwdata[1] && pwdata[0])) else $error("bad start");
    AST_ABORT: assert property (s_abort |=> !sample_active && !conversion_done)
        else $error("abort failed");
    AST_RESTART: assert property (sample_active && ctrl_wr && pwdata[1:0] == 2'h3
        && cnt < 8'd50 |=> sample_active) else $error("restart stopped");
    AST_TIME: assert property (conversion_done |-> cnt == 8'd52 && !sample_active)
        else $error("conversion length");
    AST_LIMIT: assert property (sample_active |-> cnt < 8'd52)
        else $error("conversion overran");
    AST_SLEEP: assert property (s_sleep |=> !converter_power && !sample_active
        && channel_select == 2'h3 && $stable(pins)) else $error("sleep entry");
endmodule
bind adcc_top adcc_top_assertions u_chk (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .sleep_enter(sleep_enter), .converter_power(converter_power),
    .pin0_analog_select(pin0_analog_select), .pin1_analog_select(pin1_analog_select),
    .channel_select(channel_select), .reference_select(reference_select),
    .sample_active(sample_active), .conversion_done(conversion_done));

/* tb_top.sv */
// Self-checking testbench for the converter control block
`timescale 1ns/1ps
module tb_top import adcc_pkg::*;;
    logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, sleep_enter = 1'b0, comp_in = 1'b1, err, pready, pslverr;
    logic pwr, pin0, pin1, refsel, busy, done;
    logic [1:0] chan;
    logic [7:0] paddr = 8'h00;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    int fail_count = 0, check_count = 0, n;
    // Bus clock
    always #2 pclk = ~pclk;
    adcc_top i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep_enter(sleep_enter),
        .comp_in(comp_in), .converter_power(pwr), .pin0_analog_select(pin0),
        .pin1_analog_select(pin1), .channel_select(chan), .reference_select(refsel),
        .sample_active(busy), .conversion_done(done));
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic finish_test;
        $display("Checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // One APB transfer; read data and error taken at the completing edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            fail_count++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Reset value, every channel code, reserved bits, pins, unmapped address
    task automatic s_fields;
        logic [31:0] v;
        apb(1'b0, CONTROL_OFFSET, 32'h0);
        chk("control reset", 32'hcc, rd);
        for (int c = 0; c < 4; c++) begin
            v = 32'(c) << 2 | 32'(c) << 6 | 32'h1;
            apb(1'b1, CONTROL_OFFSET, v | 32'h30);
            apb(1'b0, CONTROL_OFFSET, 32'h0);
            chk("control", v, rd);
            chk("pins", 32'(c), {pin1, pin0});
            chk("channel", 32'(c) | (c > 1 ? 32'h4 : 32'h0), {refsel, chan});
        end
        apb(1'b1, CONTROL_OFFSET, 32'hc0);
        chk("power pins", 32'h3, {pwr, pin1, pin0});
        apb(1'b0, 8'h0c, 32'h0);
        chk("unmapped", 32'h1, {rd[30:0], err});
    endtask
    // Start request while the converter is off
    task automatic s_no_start;
        apb(1'b1, CONTROL_OFFSET, 32'h02);
        chk("busy off", 32'h0, {busy, pwr});
        clk_en <= 1'b0;
        apb(1'b1, CONTROL_OFFSET, 32'hc7);
        clk_en <= 1'b1;
        chk("frozen", 32'h0, {busy, pwr, pin1, pin0});
    endtask
    // Channel, acquisition wait, full conversion with an ignored restart, read-only result
    task automatic s_convert;
        comp_in <= 1'b0;
        apb(1'b1, CONTROL_OFFSET, 32'h01);
        repeat (8) @(posedge pclk);
        apb(1'b1, CONTROL_OFFSET, 32'h03);
        apb(1'b1, CONTROL_OFFSET, 32'h03);
        n = 4;
        @(negedge pclk);
        while (busy === 1'b1 && n < 80) begin
            @(negedge pclk);
            n++;
        end
        chk("length", CONV_CLOCKS, n);
        chk("done", 32'h1, done);
        if (busy !== 1'b0) finish_test();
        @(posedge pclk);
        apb(1'b1, RESULT_OFFSET, 32'h5a);
        apb(1'b0, RESULT_OFFSET, 32'h0);
        chk("result", 32'h00, rd);
        apb(1'b0, CONTROL_OFFSET, 32'h0);
        chk("idle", 32'h1, rd);
    endtask
    // Software abort after two shifts leaves marker and one bit
    task automatic s_abort;
        comp_in <= 1'b1;
        apb(1'b1, CONTROL_OFFSET, 32'h03);
        repeat (16) @(posedge pclk);
        apb(1'b1, CONTROL_OFFSET, 32'h01);
        apb(1'b0, RESULT_OFFSET, 32'h0);
        chk("partial", 32'hc0, {busy, rd[30:0]});
    endtask
    // Sleep during a conversion
    task automatic s_sleep;
        apb(1'b1, CONTROL_OFFSET, 32'h43);
        sleep_enter <= 1'b1;
        @(posedge pclk);
        sleep_enter <= 1'b0;
        apb(1'b0, CONTROL_OFFSET, 32'h0);
        chk("sleep", 32'h4c, {busy, rd[30:0]});
        apb(1'b1, CONTROL_OFFSET, 32'h81);
        apb(1'b1, SLEEP_OFFSET, 32'h1);
        apb(1'b0, CONTROL_OFFSET, 32'h0);
        chk("sleep write", 32'h8c, {pwr, rd[30:0]});
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        s_fields();
        s_no_start();
        s_convert();
        s_abort();
        s_sleep();
        finish_test();
    end
endmodule
